// *** hdl/sfd_decoder.sv ***
// sfd_decoder.sv: single-line spi instruction decoder of a serial nor flash
// assumes: pins arrive asynchronously; array, status-write timing and the
// protection decoder sit outside on i_clk_sys and answer within two cycles
`timescale 1ns/1ps
`include "sfd_defs.svh"
module sfd_decoder
	import sfd_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'ha5, // arbitrary value
	parameter logic [7:0] PART_CODE  = 8'h5a, // arbitrary value
	parameter logic [7:0] TYPE_CODE  = 8'h3c, // arbitrary value
	parameter logic [7:0] CAP_CODE   = 8'hc3, // arbitrary value
	parameter int         FIFO_DEPTH = `SFD_FIFO_DEPTH
) (
	input  wire logic        i_clk_sys,
	input  wire logic        i_reset,
	input  wire logic        i_cs_n,
	input  wire logic        i_sclk,
	input  wire logic        i_si,
	input  wire logic        i_busy,
	input  wire logic        i_prot_hit,
	input  wire logic [7:0]  i_arr_rd_data,
	input  wire logic [7:0]  i_security_byte,
	input  wire logic        i_prog_ready,
	output logic             o_so,
	output logic             o_so_oe_n,
	output sfd_cmd_t         o_cmd_kind,
	output logic             o_cmd_valid,
	output logic [23:0]      o_cmd_addr,
	output logic [23:0]      o_arr_addr,
	output sfd_space_t       o_arr_space,
	output logic [7:0]       o_prog_data,
	output logic             o_prog_valid,
	output logic [15:0]      o_status,
	output logic             o_power_down,
	output logic             o_otp_mode
);
	logic        cs_s;
	logic        sclk_s;
	logic        si_s;
	logic        cs_d_q;
	logic        sclk_d_q;
	logic        cs_fall;
	logic        cs_rise;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        active;
	logic [7:0]  sh_q;
	logic [2:0]  bit_q;
	logic [3:0]  cnt_q;
	logic        byte_done;
	logic [7:0]  in_byte;
	sfd_state_t  st_q;
	sfd_state_t  st_d;
	logic [7:0]  op_q;
	logic        acc_q;
	logic [15:0] sr_q;
	logic [15:0] sr_new_q;
	logic [15:0] sr_rd;
	logic        vwe_q;
	logic        ovf_q;
	logic        pushed_q;
	logic [7:0]  out_q;
	logic [2:0]  oc_q;
	logic [1:0]  rix_q;
	logic [7:0]  next_byte;
	logic        load;
	logic        arr_load;
	logic        push;
	logic        fifo_ready;
	logic        aligned;
	logic        wr_go;
	logic        sr_len_ok;

	// opcodes that alter the array or a register
	function automatic logic op_writes(input logic [7:0] op);
		case (op)
			`SFD_OP_WRSR1, `SFD_OP_WRSR2, `SFD_OP_PROG, `SFD_OP_SE4, `SFD_OP_BE32,
			`SFD_OP_BE64, `SFD_OP_CE1, `SFD_OP_CE2, `SFD_OP_WRSEC: op_writes = 1'b1;
			default: op_writes = 1'b0;
		endcase
	endfunction

	// opcodes that read the array, so the address walks on
	function automatic logic op_arr_read(input logic [7:0] op);
		op_arr_read = (op == `SFD_OP_READ) || (op == `SFD_OP_FREAD) || (op == `SFD_OP_SFDP);
	endfunction

	// power-down wakes only on the release code; busy lets status reads and suspend through
	function automatic logic op_allowed(input logic [7:0] op, input logic dpd,
		input logic busy);
		if (dpd) begin
			op_allowed = (op == `SFD_OP_RDPD);
		end else if (busy) begin
			op_allowed = (op == `SFD_OP_RDSR1) || (op == `SFD_OP_RDSR2) ||
				(op == `SFD_OP_SUSP);
		end else begin
			case (op)
				`SFD_OP_WREN, `SFD_OP_WRDI, `SFD_OP_VWREN, `SFD_OP_RDSR1, `SFD_OP_RDSR2,
				`SFD_OP_READ, `SFD_OP_FREAD, `SFD_OP_RESUME, `SFD_OP_DPD, `SFD_OP_RDPD,
				`SFD_OP_MFID, `SFD_OP_JEDEC, `SFD_OP_OTPIN, `SFD_OP_OTPOUT, `SFD_OP_RDSEC,
				`SFD_OP_SFDP, `SFD_OP_SUSP: op_allowed = 1'b1;
				default: op_allowed = op_writes(op);
			endcase
		end
	endfunction

	// chip select, clock and data cross into i_clk_sys together
	sfd_sync #(
		.W   (3),
		.RST (`SFD_SYNC_RST)
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_reset   (i_reset),
		.i_async   ({i_si, i_sclk, i_cs_n}),
		.o_sync    ({si_s, sclk_s, cs_s})
	);

	// edge finding on the synchronised pins
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			cs_d_q   <= 1'b1;
			sclk_d_q <= 1'b0;
		end else begin
			cs_d_q   <= cs_s;
			sclk_d_q <= sclk_s;
		end
	end
	assign active    = !cs_s;
	assign cs_fall   = !cs_s && cs_d_q;
	assign cs_rise   = cs_s && !cs_d_q;
	assign sclk_rise = sclk_s && !sclk_d_q;
	assign sclk_fall = !sclk_s && sclk_d_q;
	assign in_byte   = {sh_q[6:0], si_s};
	assign byte_done = active && sclk_rise && (bit_q == 3'd7);
	assign aligned   = (bit_q == 3'd0);

	// input shifter, bit and byte counters; bytes counted saturate at 15
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			sh_q  <= '0;
			bit_q <= '0;
			cnt_q <= '0;
		end else if (cs_fall) begin
			bit_q <= '0;
			cnt_q <= '0;
		end else if (active && sclk_rise) begin
			sh_q  <= in_byte;
			bit_q <= bit_q + 3'd1;
			if (byte_done && cnt_q != 4'hf) begin
				cnt_q <= cnt_q + 4'd1;
			end
		end
	end

	// phase of the instruction, stepped once per byte
	always_comb begin
		st_d = st_q;
		if (cs_rise) begin
			st_d = ST_IDLE;
		end else if (cs_fall) begin
			st_d = ST_OP;
		end else if (byte_done) begin
			case (st_q)
				ST_OP: begin
					st_d = ST_SKIP;
					if (op_allowed(in_byte, o_power_down, i_busy)) begin
						case (in_byte)
							`SFD_OP_READ, `SFD_OP_FREAD, `SFD_OP_PROG, `SFD_OP_SE4,
							`SFD_OP_BE32, `SFD_OP_BE64, `SFD_OP_MFID,
							`SFD_OP_SFDP: st_d = ST_ADDR;
							`SFD_OP_RDPD: st_d = ST_DUMMY;
							`SFD_OP_RDSR1, `SFD_OP_RDSR2, `SFD_OP_RDSEC,
							`SFD_OP_JEDEC: st_d = ST_RDATA;
							`SFD_OP_WRSR1, `SFD_OP_WRSR2: st_d = ST_WDATA;
							default: st_d = ST_SKIP;
						endcase
					end
				end
				ST_ADDR: begin
					if (cnt_q == 4'd3) begin
						case (op_q)
							`SFD_OP_READ, `SFD_OP_MFID: st_d = ST_RDATA;
							`SFD_OP_FREAD, `SFD_OP_SFDP: st_d = ST_DUMMY;
							`SFD_OP_PROG: st_d = ST_WDATA;
							default: st_d = ST_SKIP;
						endcase
					end
				end
				ST_DUMMY: begin
					if (cnt_q == ((op_q == `SFD_OP_RDPD) ? 4'd3 : 4'd4)) begin
						st_d = ST_RDATA;
					end
				end
				default: st_d = st_q;
			endcase
		end
	end

	// state, opcode and its acceptance
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st_q  <= ST_IDLE;
			op_q  <= '0;
			acc_q <= 1'b0;
		end else begin
			st_q <= st_d;
			if (cs_fall) begin
				acc_q <= 1'b0;
			end else if (st_q == ST_OP && byte_done) begin
				op_q  <= in_byte;
				acc_q <= op_allowed(in_byte, o_power_down, i_busy);
			end
		end
	end

	// array address: loaded msb first, then walks on each byte sent
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_arr_addr  <= '0;
			o_arr_space <= SP_MAIN;
		end else if (st_q == ST_ADDR && byte_done) begin
			o_arr_addr  <= {o_arr_addr[15:0], in_byte};
			o_arr_space <= (op_q == `SFD_OP_SFDP) ? SP_SFDP :
				(o_otp_mode ? SP_OTP : SP_MAIN);
		end else if (arr_load) begin
			o_arr_addr <= o_arr_addr + 24'd1;
		end
	end

	// staged status bytes and program data into the fifo
	assign push = byte_done && st_q == ST_WDATA && op_q == `SFD_OP_PROG &&
		sr_q[`SFD_SR_WEL];
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || cs_fall) begin
			ovf_q    <= 1'b0;
			pushed_q <= 1'b0;
		end else if (push) begin
			pushed_q <= 1'b1;
			if (!fifo_ready) begin
				ovf_q <= 1'b1; // a lost byte spoils the whole page
			end
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			sr_new_q <= `SFD_SR_RST;
		end else if (st_q == ST_OP && byte_done) begin
			sr_new_q <= sr_q;
		end else if (st_q == ST_WDATA && byte_done) begin
			if (op_q == `SFD_OP_WRSR1 && cnt_q == 4'd1) begin
				sr_new_q[7:0] <= in_byte;
			end else if (cnt_q == 4'd1 || (op_q == `SFD_OP_WRSR1 && cnt_q == 4'd2)) begin
				sr_new_q[15:8] <= in_byte;
			end
		end
	end

	sfd_fifo #(
		.W (`SFD_DATA_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.i_clk_sys   (i_clk_sys),
		.i_reset     (i_reset),
		.i_in_data   (in_byte),
		.i_in_valid  (push),
		.o_in_ready  (fifo_ready),
		.o_out_data  (o_prog_data),
		.o_out_valid (o_prog_valid),
		.i_out_ready (i_prog_ready)
	);

	// actions at the end of the frame; writes need whole bytes and write enable
	assign wr_go     = aligned && sr_q[`SFD_SR_WEL];
	assign sr_len_ok = aligned && (cnt_q == 4'd2 ||
		(op_q == `SFD_OP_WRSR1 && cnt_q == 4'd3));
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			sr_q         <= `SFD_SR_RST;
			vwe_q        <= 1'b0;
			o_power_down <= 1'b0;
			o_otp_mode   <= 1'b0;
			o_cmd_valid  <= 1'b0;
			o_cmd_kind   <= CK_NONE;
			o_cmd_addr   <= '0;
		end else begin
			o_cmd_valid <= 1'b0;
			if (cs_rise && acc_q) begin
				o_cmd_addr <= o_arr_addr;
				case (op_q)
					`SFD_OP_WREN: sr_q[`SFD_SR_WEL] <= 1'b1;
					`SFD_OP_WRDI: sr_q[`SFD_SR_WEL] <= 1'b0;
					`SFD_OP_VWREN: vwe_q <= aligned && (cnt_q == 4'd1);
					`SFD_OP_WRSR1, `SFD_OP_WRSR2: begin
						if (sr_len_ok && (vwe_q || sr_q[`SFD_SR_WEL])) begin
							sr_q <= (sr_q & ~`SFD_SR_WMASK & ~`SFD_SR_WELM) |
								(sr_new_q & `SFD_SR_WMASK);
							o_cmd_valid <= !vwe_q;
							o_cmd_kind  <= CK_SRWR;
						end
						vwe_q <= 1'b0;
					end
					`SFD_OP_PROG: begin
						if (wr_go && cnt_q > 4'd4 && !i_prot_hit && !ovf_q) begin
							o_cmd_valid       <= 1'b1;
							o_cmd_kind        <= CK_PROG;
							sr_q[`SFD_SR_WEL] <= 1'b0;
						end else if (pushed_q) begin
							o_cmd_valid <= 1'b1;
							o_cmd_kind  <= CK_ABORT;
						end
					end
					`SFD_OP_SE4, `SFD_OP_BE32, `SFD_OP_BE64: begin
						if (wr_go && cnt_q == 4'd4 && !i_prot_hit) begin
							o_cmd_valid       <= 1'b1;
							o_cmd_kind        <= (op_q == `SFD_OP_SE4) ? CK_ERASE4K :
								((op_q == `SFD_OP_BE32) ? CK_ERASE32K : CK_ERASE64K);
							sr_q[`SFD_SR_WEL] <= 1'b0;
						end
					end
					`SFD_OP_CE1, `SFD_OP_CE2: begin
						if (wr_go && cnt_q == 4'd1 && !i_prot_hit) begin
							o_cmd_valid       <= 1'b1;
							o_cmd_kind        <= CK_CHIP;
							sr_q[`SFD_SR_WEL] <= 1'b0;
						end
					end
					`SFD_OP_WRSEC: begin
						if (wr_go && cnt_q == 4'd1) begin
							o_cmd_valid       <= 1'b1;
							o_cmd_kind        <= CK_SECWR;
							sr_q[`SFD_SR_WEL] <= 1'b0;
						end
					end
					`SFD_OP_SUSP: begin
						if (aligned && cnt_q == 4'd1) begin
							o_cmd_valid       <= 1'b1;
							o_cmd_kind        <= CK_SUSPEND;
							sr_q[`SFD_SR_SUSPENDED] <= 1'b1;
						end
					end
					`SFD_OP_RESUME: begin
						if (aligned && cnt_q == 4'd1) begin
							o_cmd_valid       <= 1'b1;
							o_cmd_kind        <= CK_RESUME;
							sr_q[`SFD_SR_SUSPENDED] <= 1'b0;
						end
					end
					`SFD_OP_DPD: o_power_down <= aligned && (cnt_q == 4'd1);
					`SFD_OP_RDPD: o_power_down <= 1'b0;
					`SFD_OP_OTPIN: o_otp_mode <= 1'b1;
					`SFD_OP_OTPOUT: o_otp_mode <= 1'b0;
					default: o_cmd_valid <= 1'b0;
				endcase
			end
		end
	end

	// busy bit is live so a poll sees the cycle end at once
	assign sr_rd = {sr_q[15:1], i_busy};
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_status <= `SFD_SR_RST;
		end else begin
			o_status <= sr_rd;
		end
	end

	// byte to send next, chosen at the first falling edge of each byte
	always_comb begin
		case (op_q)
			`SFD_OP_RDSR1: next_byte = sr_rd[7:0];
			`SFD_OP_RDSR2: next_byte = sr_rd[15:8];
			`SFD_OP_RDSEC: next_byte = i_security_byte;
			`SFD_OP_RDPD: next_byte = PART_CODE;
			`SFD_OP_MFID: next_byte = (rix_q[0] ^ o_arr_addr[0]) ? PART_CODE : MAKER_CODE;
			`SFD_OP_JEDEC: next_byte = (rix_q == 2'd0) ? MAKER_CODE :
				((rix_q == 2'd1) ? TYPE_CODE : CAP_CODE);
			default: next_byte = i_arr_rd_data;
		endcase
	end
	assign load     = sclk_fall && (st_q == ST_RDATA) && (oc_q == 3'd0);
	assign arr_load = load && op_arr_read(op_q);

	// output shifter; changes on the falling edge so the host samples stable data
	always_ff @(posedge i_clk_sys) begin
		if (i_reset || st_q != ST_RDATA) begin
			oc_q  <= '0;
			rix_q <= '0;
			out_q <= '0;
		end else if (sclk_fall) begin
			oc_q  <= oc_q + 3'd1;
			out_q <= load ? next_byte : {out_q[6:0], 1'b0};
			if (load) begin
				rix_q <= (op_q == `SFD_OP_JEDEC && rix_q == 2'd2) ? 2'd0 : rix_q + 2'd1;
			end
		end
	end

	// data pin and its enable, low while driving
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_so      <= 1'b0;
			o_so_oe_n <= 1'b1;
		end else begin
			o_so_oe_n <= !(active && st_q == ST_RDATA);
			if (st_q == ST_RDATA && sclk_fall) begin
				o_so <= load ? next_byte[7] : out_q[6];
			end
		end
	end

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);

	sequence s_frame_start;
		cs_fall ##1 (st_q == ST_OP);
	endsequence
	sequence s_id_out;
		(st_q == ST_RDATA) ##[1:40] (load && next_byte == PART_CODE);
	endsequence

	frame_start_a: assert property (cs_fall |-> s_frame_start)
		else $error("frame did not start at chip select fall");
	opcode_latch_a: assert property ((st_q == ST_OP && byte_done) |=>
		(op_q == $past(in_byte))) else $error("first byte not taken as opcode");
	msb_first_a: assert property ((active && sclk_rise && !byte_done) |=>
		(sh_q[0] == $past(si_s) && sh_q[7:1] == $past(sh_q[6:0])))
		else $error("input bit not shifted in msb first");
	commit_edge_a: assert property ($rose(o_cmd_valid) |-> $past(cs_rise))
		else $error("command issued away from chip select rise");
	whole_byte_a: assert property ((cs_rise && !aligned && op_writes(op_q)) |=>
		(!o_cmd_valid || o_cmd_kind == CK_ABORT)) else $error("partial byte write acted");
	busy_ignore_a: assert property ((st_q == ST_OP && byte_done && i_busy &&
		!o_power_down && in_byte != `SFD_OP_RDSR1 && in_byte != `SFD_OP_RDSR2 &&
		in_byte != `SFD_OP_SUSP) |=> !acc_q)
		else $error("instruction accepted while busy");
	suspend_flag_a: assert property ((o_cmd_valid && o_cmd_kind == CK_SUSPEND) |->
		sr_q[`SFD_SR_SUSPENDED]) else $error("suspend issued without suspended flag");
	addr_step_a: assert property (arr_load |=>
		(o_arr_addr == $past(o_arr_addr) + 24'd1)) else $error("read address did not step");
	// a host that ends the frame without clocking the code out owes no code
	id_read_a: assert property (disable iff (i_reset || cs_s)
		(st_q == ST_DUMMY && op_q == `SFD_OP_RDPD && byte_done && cnt_q == 4'd3) |=>
		s_id_out) else $error("part code not sent");
endmodule

// *** hdl/sfd_defs.svh ***
// sfd_defs.svh: opcodes, status layout, sizes and reset values of the flash decoder
// assumes: included by bare name from every decoder module
`ifndef SFD_DEFS_SVH
`define SFD_DEFS_SVH
`define SFD_OP_WREN   8'h06
`define SFD_OP_WRDI   8'h04
`define SFD_OP_VWREN  8'h50
`define SFD_OP_RDSR1  8'h05
`define SFD_OP_RDSR2  8'h35
`define SFD_OP_WRSR1  8'h01
`define SFD_OP_WRSR2  8'h31
`define SFD_OP_READ   8'h03
`define SFD_OP_FREAD  8'h0b
`define SFD_OP_PROG   8'h02
`define SFD_OP_SE4    8'h20
`define SFD_OP_BE32   8'h52
`define SFD_OP_BE64   8'hd8
`define SFD_OP_CE1    8'h60
`define SFD_OP_CE2    8'hc7
`define SFD_OP_SUSP   8'h75
`define SFD_OP_RESUME 8'h7a
`define SFD_OP_DPD    8'hb9
`define SFD_OP_RDPD   8'hab
`define SFD_OP_MFID   8'h90
`define SFD_OP_JEDEC  8'h9f
`define SFD_OP_OTPIN  8'hb1
`define SFD_OP_OTPOUT 8'hc1
`define SFD_OP_RDSEC  8'h2b
`define SFD_OP_WRSEC  8'h2f
`define SFD_OP_SFDP   8'h5a
`define SFD_SR_BUSY   0
`define SFD_SR_WEL    1
`define SFD_SR_SUSPENDED 15
`define SFD_SR_RST    16'h0000
`define SFD_SR_WMASK  16'h7ffc
`define SFD_SR_WELM   16'h0002
`define SFD_DATA_W    8
`define SFD_FIFO_DEPTH 16
`define SFD_SYNC_RST  3'h1
`endif

// *** hdl/sfd_pkg.sv ***
// sfd_pkg.sv: types shared by the flash decoder modules
// assumes: nothing beyond the tool's package support
package sfd_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_OP, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA,
		ST_SKIP} sfd_state_t;
	typedef enum logic [3:0] {CK_NONE, CK_PROG, CK_ABORT, CK_ERASE4K, CK_ERASE32K,
		CK_ERASE64K, CK_CHIP, CK_SUSPEND, CK_RESUME, CK_SRWR, CK_SECWR} sfd_cmd_t;
	typedef enum logic [1:0] {SP_MAIN, SP_SFDP, SP_OTP} sfd_space_t;
endpackage

// *** hdl/sfd_sync.sv ***
// sfd_sync.sv: two-stage synchroniser for pin inputs
// assumes: inputs are asynchronous to i_clk_sys; only the second stage is read
`timescale 1ns/1ps
`include "sfd_defs.svh"
module sfd_sync #(
	parameter int             W   = 3,
	parameter logic [W-1:0]   RST = `SFD_SYNC_RST
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_reset,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_q;

	// reset to idle levels so no false chip select edge appears at release
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			meta_q <= RST;
			o_sync <= RST;
		end else begin
			meta_q <= i_async;
			o_sync <= meta_q;
		end
	end
endmodule

// *** hdl/sfd_fifo.sv ***
// sfd_fifo.sv: shift-register fifo, head always in slot 0
// assumes: one clock; a push without o_in_ready or a pop without o_out_valid is ignored
`timescale 1ns/1ps
`include "sfd_defs.svh"
module sfd_fifo #(
	parameter int W = `SFD_DATA_W,
	parameter int D = `SFD_FIFO_DEPTH
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_reset,
	input  wire logic [W-1:0] i_in_data,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	output logic      [W-1:0] o_out_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready
);
	localparam int CW = $clog2(D + 1);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic          push;
	logic          pop;

	assign o_in_ready = (cnt_q != CW'(D));
	assign push       = i_in_valid && o_in_ready;
	assign pop        = o_out_valid && i_out_ready;
	assign cnt_d      = cnt_q + CW'(push) - CW'(pop);

	// head slot is a flop so the drain side sees registered data
	for (genvar i = 0; i < D; i++) begin : g_slot
		logic [W-1:0] q;
		logic [W-1:0] above;
		if (i == D - 1) begin : g_last
			assign above = q;
		end else begin : g_mid
			assign above = g_slot[i + 1].q;
		end
		always_ff @(posedge i_clk_sys) begin
			if (pop) begin
				q <= (push && CW'(i + 1) == cnt_q) ? i_in_data : above;
			end else if (push && CW'(i) == cnt_q) begin
				q <= i_in_data;
			end
		end
	end
	assign o_out_data = g_slot[0].q;

	// fill level and a registered valid
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			cnt_q       <= '0;
			o_out_valid <= 1'b0;
		end else begin
			cnt_q       <= cnt_d;
			o_out_valid <= (cnt_d != '0);
		end
	end
endmodule

// *** sim/sfd_host_model.sv ***
// sfd_host_model.sv: single-line spi host driving the decoder's pins
// assumes: called by the bench one frame at a time; sclk parked low (mode 0)
`timescale 1ns/1ps
module sfd_host_model (
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_si,
	input  wire logic i_so
);
	// idle pins; the link clock stands still between frames
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_si   = 1'b0;
	end
	// one frame: tx bytes, xb stray bits (deliberate misalignment), then nrd bytes read
	task automatic frame(input logic [7:0] tx[$], input int nrd, input int xb,
		output logic [7:0] rx[$]);
		int nb;
		logic [7:0] b;
		nb = tx.size() * 8;
		rx = {};
		o_cs_n = 1'b0;
		#150;
		for (int n = 0; n < nb + xb + nrd * 8; n++) begin
			o_si = (n < nb) ? tx[n / 8][7 - n % 8] : ~o_si;
			#100 o_sclk = 1'b1;
			#100 b = {b[6:0], i_so}; // sampled late: so only settles ~3 sys clocks after fall
			o_sclk = 1'b0;
			if (n >= nb + xb && (n - nb - xb) % 8 == 7)
				rx.push_back(b);
		end
		#100 o_cs_n = 1'b1;
		o_si = ~o_si; // released line must not look stable
		#300;
	endtask
endmodule

// *** sim/sfd_decoder_tb.sv ***
// sfd_decoder_tb.sv: self-checking bench for the flash instruction decoder
// assumes: host model drives the pins; array bytes come from a bench function
`timescale 1ns/1ps
module sfd_decoder_tb;
	import sfd_pkg::*;
	localparam logic [7:0] MK = 8'h4d; // arbitrary value
	localparam logic [7:0] PT = 8'h71; // arbitrary value
	localparam logic [7:0] TY = 8'h2e; // arbitrary value
	localparam logic [7:0] CP = 8'h63; // arbitrary value
	localparam logic [7:0] RD [3] = '{8'h03, 8'h0b, 8'h5a};
	localparam logic [7:0] ER [5] = '{8'h20, 8'h52, 8'hd8, 8'h60, 8'hc7};
	localparam sfd_cmd_t   EK [5] = '{CK_ERASE4K, CK_ERASE32K, CK_ERASE64K, CK_CHIP, CK_CHIP};
	logic        i_clk_sys = 1'b0, i_reset = 1'b1, i_busy = 1'b0, i_prot_hit = 1'b0;
	logic        i_prog_ready = 1'b1, i_cs_n, i_sclk, i_si, o_so, o_so_oe_n;
	logic        o_cmd_valid, o_prog_valid, o_power_down, o_otp_mode, oe_seen = 1'b0;
	logic [7:0]  i_security_byte = 8'h00, i_arr_rd_data, o_prog_data, rx[$], pops[$];
	logic [23:0] o_cmd_addr, o_arr_addr, last_addr;
	logic [15:0] o_status;
	logic [31:0] seed = 32'ha0c4;
	sfd_cmd_t    o_cmd_kind, last_kind;
	sfd_space_t  o_arr_space;
	int          bad_count = 0, checks_done = 0, cyc = 0, cmd_n = 0;
	sfd_decoder #(.MAKER_CODE(MK), .PART_CODE(PT), .TYPE_CODE(TY), .CAP_CODE(CP)) i_sfd_decoder (
		.i_clk_sys, .i_reset, .i_cs_n, .i_sclk, .i_si, .i_busy, .i_prot_hit, .i_arr_rd_data,
		.i_security_byte, .i_prog_ready, .o_so, .o_so_oe_n, .o_cmd_kind, .o_cmd_valid,
		.o_cmd_addr, .o_arr_addr, .o_arr_space, .o_prog_data, .o_prog_valid, .o_status,
		.o_power_down, .o_otp_mode);
	sfd_host_model i_sfd_host_model (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_si(i_si), .i_so(o_so));
	// array contents: a fixed scramble of the address
	function automatic logic [7:0] memf(logic [23:0] a);
		return a[7:0] ^ a[23:16] ^ 8'h96;
	endfunction
	assign i_arr_rd_data = memf(o_arr_addr);
	function automatic logic [23:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[23:0];
	endfunction
	initial begin
		forever #12.5 i_clk_sys = ~i_clk_sys;
	end
	task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge i_clk_sys);
		#2;
	endtask
	task automatic run(input logic [7:0] tx[$], input int nrd = 0, input int xb = 0);
		i_sfd_host_model.frame(tx, nrd, xb, rx);
	endtask
	// command and drain monitor; also cuts a hang short
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (o_cmd_valid === 1'b1) begin
			cmd_n <= cmd_n + 1;
			last_kind <= o_cmd_kind;
			last_addr <= o_cmd_addr;
		end
		if (o_prog_valid === 1'b1 && i_prog_ready)
			pops.push_back(o_prog_data);
		// remembers whether the data pin was driven since the bench last cleared it
		if (o_so_oe_n === 1'b0)
			oe_seen <= 1'b1;
		if (cyc == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end
	initial begin
		logic [23:0] a;
		logic [7:0] d0, d1, tx[$];
		int n0;
		tick(6);
		i_reset = 1'b0;
		tick(4);
		check("status_rst", {o_cmd_kind, o_status, o_so_oe_n}, {CK_NONE, 16'h0000, 1'b1});
		run({8'h9f}, 4);
		check("jedec", {rx[0], rx[1], rx[2], rx[3]}, {MK, TY, CP, MK});
		check("so_drive", {oe_seen, o_so_oe_n}, 2'b11);
		for (int i = 0; i < 2; i++) begin
			run({8'h90, 8'h00, 8'h00, 8'(i)}, 2);
			check("mfid", {rx[0], rx[1]}, i ? {PT, MK} : {MK, PT});
		end
		foreach (RD[i]) begin
			a = xs();
			tx = {RD[i], a[23:16], a[15:8], a[7:0]};
			if (i > 0)
				tx.push_back(8'(xs()));
			run(tx, 2);
			check("read", {rx[0], rx[1]}, {memf(a), memf(a + 24'h1)});
		end
		check("space", o_arr_space, SP_SFDP);
		n0 = cmd_n;
		foreach (ER[i]) begin
			a = xs();
			run({8'h06});
			tx = {ER[i]};
			if (i < 3)
				tx = {tx, a[23:16], a[15:8], a[7:0]};
			run(tx);
			check("erase", last_kind, EK[i]);
			if (i < 3)
				check("erase_addr", last_addr, a);
		end
		check("erase_n", cmd_n, n0 + 5);
		a = xs();
		d0 = 8'(xs());
		d1 = 8'(xs());
		pops = {};
		run({8'h06});
		run({8'h02, a[23:16], a[15:8], a[7:0], d0, d1});
		check("prog", {last_kind, last_addr, o_status[1]}, {CK_PROG, a, 1'b0});
		check("prog_data", {pops[0], pops[1]}, {d0, d1});
		n0 = cmd_n;
		run({8'h06});
		run({8'h20, a[23:16], a[15:8], a[7:0]}, 0, 3);
		i_prot_hit = 1'b1;
		run({8'h20, a[23:16], a[15:8], a[7:0]});
		i_prot_hit = 1'b0;
		check("no_cmd", cmd_n, n0);
		run({8'h06});
		run({8'h01, 8'hff, 8'hff});
		check("srwr", {last_kind, o_status}, {CK_SRWR, 16'h7ffc});
		run({8'h06});
		run({8'h31, 8'h00});
		check("sr2", o_status, 16'h00fc);
		run({8'h06});
		run({8'h05}, 2);
		check("rdsr1", {rx[0], rx[1]}, 16'hfefe);
		run({8'h35}, 1);
		check("rdsr2", rx[0], 8'h00);
		n0 = cmd_n;
		run({8'h50});
		run({8'h01, 8'h00});
		check("vol_sr", {o_status[15:2], 8'(cmd_n - n0)}, 22'h0);
		run({8'h06});
		i_busy = 1'b1;
		run({8'h04});
		check("busy", o_status[1:0], 2'b11);
		run({8'h75});
		check("susp", {last_kind, o_status[15]}, {CK_SUSPEND, 1'b1});
		i_busy = 1'b0;
		run({8'h7a});
		check("resume", {last_kind, o_status[15]}, {CK_RESUME, 1'b0});
		run({8'hb9});
		check("pd_on", o_power_down, 1'b1);
		oe_seen = 1'b0;
		run({8'h9f}, 1);
		check("pd_refuse", {oe_seen, o_power_down}, 2'b01);
		run({8'hab, 8'h00, 8'h00, 8'h00}, 1);
		check("pd_off", {o_power_down, rx[0]}, {1'b0, PT});
		run({8'hb1});
		check("otp_on", o_otp_mode, 1'b1);
		run({8'h03, 8'h00, 8'h00, 8'h00}, 1);
		check("otp_space", {o_arr_space, rx[0]}, {SP_OTP, memf(24'h0)});
		run({8'hc1});
		check("otp_off", o_otp_mode, 1'b0);
		i_security_byte = 8'(xs());
		run({8'h2b}, 1);
		check("rdsec", rx[0], i_security_byte);
		run({8'h06});
		run({8'h2f});
		check("wrsec", last_kind, CK_SECWR);
		// drain stalled: fill past 16 words, then let it empty
		i_prog_ready = 1'b0;
		run({8'h06});
		tx = {8'h02, 8'h00, 8'h00, 8'h00};
		repeat (17) tx.push_back(8'(xs()));
		pops = {};
		run(tx);
		check("overflow", last_kind, CK_ABORT);
		i_prog_ready = 1'b1;
		tick(40);
		check("drain", pops.size(), 16);
		report_and_stop();
	end
endmodule
